// ===== logic/vcr_regs.sv
// VC0 resource capability, control and status registers
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "vcr_cfg.svh"
module vcr_regs (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   input  wire logic [11:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic        i_mgmt_wr,
   input  wire logic [7:0]  i_mgmt_tc_map,
   input  wire logic        i_tbl_entry_wr,
   input  wire logic        i_tbl_load_done,
   input  wire logic        i_neg_pending,
   output logic [31:0]      o_rdata,
   output logic [7:0]       o_tc_map,
   output logic [2:0]       o_arb_sel,
   output logic             o_vc_en,
   output logic             o_tbl_load_req,
   output logic             o_tbl_pending
);
   vcr_pkg::vcr_bus_req_t req;
   vcr_pkg::vcr_ctrl_t    ctrl_reg;
   logic                  sw_touched_reg;
   logic                  neg_level;
   logic                  load_pulse;
   logic                  wr_ctrl;
   logic [2:0]            sel_next;

   assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   function automatic logic [2:0] legal_sel(input logic [2:0] s);
      // Time-based scheme belongs to VC1 only
      if (s == `VCR_SEL_DEFAULT || s == `VCR_SEL_WEIGHTED) begin
         legal_sel = s;
      end else begin
         legal_sel = `VCR_SEL_DEFAULT;
      end
   endfunction : legal_sel

   function automatic logic [31:0] cap_word();
      logic [31:0] w;
      w = 32'h0;
      w[7:0]   = `VCR_CAP_ARB_RST;
      w[14]    = 1'h0;
      w[15]    = 1'h0;
      w[22:16] = `VCR_CAP_SLOTS_RST;
      w[31:24] = `VCR_CAP_TBL_RST;
      cap_word = w;
   endfunction : cap_word

   assign wr_ctrl    = req.wr && hit(req.addr, `VCR_OFF_CTRL);
   assign load_pulse = wr_ctrl && req.wdata[`VCR_CTRL_LOAD_BIT];
   assign sel_next   = legal_sel(req.wdata[`VCR_CTRL_SEL_LSB +: 3]);

   // ---------------------------------------------
   // Control register
   // ---------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg.tc_map  <= `VCR_TCMAP_RST;
         ctrl_reg.arb_sel <= `VCR_SEL_DEFAULT;
         ctrl_reg.vc_en   <= `VCR_EN_RST;
         sw_touched_reg   <= 1'h0;
      end else if (i_ce) begin
         if (wr_ctrl) begin
            ctrl_reg.tc_map  <= req.wdata[`VCR_CTRL_TCMAP_LSB +: 8];
            ctrl_reg.arb_sel <= sel_next;
            ctrl_reg.vc_en   <= req.wdata[`VCR_CTRL_EN_BIT];
            sw_touched_reg   <= 1'h1;
         end else if (i_mgmt_wr && !sw_touched_reg) begin
            ctrl_reg.tc_map  <= i_mgmt_tc_map;
         end
         if (req.rd || req.wr) begin
            sw_touched_reg <= 1'h1;
         end
      end
   end

   // ---------------------------------------------
   // Table loader and negotiation input
   // ---------------------------------------------
   vcr_table_loader u_loader (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_ce        (i_ce),
      .i_entry_wr  (i_tbl_entry_wr),
      .i_load      (load_pulse),
      .i_load_done (i_tbl_load_done),
      .o_load_req  (o_tbl_load_req),
      .o_pending   (o_tbl_pending)
   );

   vcr_pin_sync u_neg_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_pin   (i_neg_pending),
      .o_level (neg_level)
   );

   // ---------------------------------------------
   // Read data, one cycle after the strobe
   // ---------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h0;
      end else if (i_ce) begin
         o_rdata <= 32'h0;
         if (req.rd) begin
            if (hit(req.addr, `VCR_OFF_CAP)) begin
               o_rdata <= cap_word();
            end else if (hit(req.addr, `VCR_OFF_CTRL)) begin
               o_rdata[7:0]   <= ctrl_reg.tc_map;
               o_rdata[16]    <= 1'h0;
               o_rdata[19:17] <= ctrl_reg.arb_sel;
               o_rdata[26:24] <= `VCR_VCID_RST;
               o_rdata[31]    <= ctrl_reg.vc_en;
            end else if (hit(req.addr, `VCR_OFF_STAT)) begin
               o_rdata[`VCR_STAT_TBL_BIT] <= o_tbl_pending;
               o_rdata[`VCR_STAT_NEG_BIT] <= neg_level;
            end
         end
      end
   end

   // ---------------------------------------------
   // Control outputs
   // ---------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_tc_map  <= `VCR_TCMAP_RST;
         o_arb_sel <= `VCR_SEL_DEFAULT;
         o_vc_en   <= `VCR_EN_RST;
      end else if (i_ce) begin
         o_tc_map  <= ctrl_reg.tc_map;
         o_arb_sel <= ctrl_reg.arb_sel;
         o_vc_en   <= ctrl_reg.vc_en;
      end
   end
endmodule : vcr_regs

// ===== common/vcr_cfg.svh
// Offsets, field positions, reset values for the VC0 resource registers
`ifndef VCR_CFG_SVH
`define VCR_CFG_SVH

`define VCR_OFF_CAP        12'h150
`define VCR_OFF_CTRL       12'h154
`define VCR_OFF_STAT       12'h158
`define VCR_ADDR_W         12

`define VCR_CAP_ARB_RST    8'h09
`define VCR_CAP_SLOTS_RST  7'h7f
`define VCR_CAP_TBL_RST    8'h04
`define VCR_TCMAP_RST      8'hff
`define VCR_SEL_DEFAULT    3'h0
`define VCR_SEL_WEIGHTED   3'h3
`define VCR_SEL_TIMED      3'h4
`define VCR_VCID_RST       3'h0
`define VCR_EN_RST         1'h1

`define VCR_CTRL_TCMAP_LSB 0
`define VCR_CTRL_LOAD_BIT  16
`define VCR_CTRL_SEL_LSB   17
`define VCR_CTRL_VCID_LSB  24
`define VCR_CTRL_EN_BIT    31
`define VCR_STAT_TBL_BIT   16
`define VCR_STAT_NEG_BIT   17

`endif

// ===== common/vcr_pkg.sv
// Types shared by the VC0 resource register block
package vcr_pkg;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } vcr_bus_req_t;

   typedef struct packed {
      logic [7:0] tc_map;
      logic [2:0] arb_sel;
      logic       vc_en;
   } vcr_ctrl_t;

   typedef enum logic [1:0] {
      VCR_LD_IDLE,
      VCR_LD_BUSY
   } vcr_ld_state_t;

endpackage : vcr_pkg

// ===== logic/vcr_pin_sync.sv
// Three-flop synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module vcr_pin_sync (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   input  wire logic i_pin,
   output logic      o_level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_reg <= 1'h0;
         s2_reg <= 1'h0;
         s3_reg <= 1'h0;
      end else if (i_ce) begin
         s1_reg <= i_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_level <= 1'h0;
      end else if (i_ce && (s2_reg == s3_reg)) begin
         o_level <= s3_reg;
      end
   end
endmodule : vcr_pin_sync

// ===== logic/vcr_table_loader.sv
// Tracks port arbitration table writes and the load handshake
`timescale 1ns/1ps
module vcr_table_loader (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   input  wire logic i_entry_wr,
   input  wire logic i_load,
   input  wire logic i_load_done,
   output logic      o_load_req,
   output logic      o_pending
);
   vcr_pkg::vcr_ld_state_t state_reg;

   // ---------------------------------------------
   // Load sequencer
   // ---------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg  <= vcr_pkg::VCR_LD_IDLE;
         o_load_req <= 1'h0;
      end else if (i_ce) begin
         case (state_reg)
            vcr_pkg::VCR_LD_IDLE: begin
               if (i_load) begin
                  state_reg  <= vcr_pkg::VCR_LD_BUSY;
                  o_load_req <= 1'h1;
               end
            end
            vcr_pkg::VCR_LD_BUSY: begin
               if (i_load_done) begin
                  state_reg  <= vcr_pkg::VCR_LD_IDLE;
                  o_load_req <= 1'h0;
               end
            end
            default: begin
               state_reg  <= vcr_pkg::VCR_LD_IDLE;
               o_load_req <= 1'h0;
            end
         endcase
      end
   end

   // ---------------------------------------------
   // Pending flag, set wins over clear
   // ---------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pending <= 1'h0;
      end else if (i_ce) begin
         if (i_entry_wr) begin
            o_pending <= 1'h1;
         end else if (state_reg == vcr_pkg::VCR_LD_BUSY && i_load_done) begin
            o_pending <= 1'h0;
         end
      end
   end
endmodule : vcr_table_loader

// ===== test/vcr_regs_monitor.sv
// Assertions on the VC0 resource register ports
`timescale 1ns/1ps
module vcr_regs_monitor (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_ce,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic        i_tbl_entry_wr,
   input wire logic        i_tbl_load_done,
   input wire logic [31:0] o_rdata,
   input wire logic [7:0]  o_tc_map,
   input wire logic [2:0]  o_arb_sel,
   input wire logic        o_vc_en,
   input wire logic        o_tbl_load_req,
   input wire logic        o_tbl_pending
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic c_wr;
   assign c_wr = i_wr && i_ce && i_addr == 12'h154;
   property p_map;
      c_wr |-> ##2 o_tc_map == $past(i_wdata[7:0], 2) &&
         o_vc_en == $past(i_wdata[31], 2);
   endproperty
   a_cap_value: assert property (i_rd && i_ce && i_addr == 12'h150 |=>
      o_rdata == 32'h047f0009) else $error("capability read wrong");
   a_rdata_quiet: assert property (
      $past(i_ce) && !$past(i_rd) |-> o_rdata == 0)
      else $error("read data not idle");
   a_ctrl_fixed: assert property (i_rd && i_ce && i_addr == 12'h154 |=>
      o_rdata[30:20] == 0 && o_rdata[16:8] == 0) else $error("ctrl bits");
   a_stat_rsvd: assert property (i_rd && i_ce && i_addr == 12'h158 |=>
      o_rdata[31:18] == 0 && o_rdata[15:0] == 0) else $error("status bits");
   a_sel_legal: assert property (o_arb_sel == 3'h0 || o_arb_sel == 3'h3)
      else $error("illegal select");
   a_sel_default: assert property (c_wr && i_wdata[19:17] != 3'h3 |->
      ##2 o_arb_sel == 3'h0) else $error("select not default");
   a_map_enable: assert property (p_map) else $error("map or enable");
   a_load_start: assert property (c_wr && i_wdata[16] |=> o_tbl_load_req)
      else $error("load not started");
   a_load_hold: assert property (o_tbl_load_req && !i_tbl_load_done |=>
      o_tbl_load_req) else $error("load dropped");
   a_pend_set: assert property (i_tbl_entry_wr && i_ce |-> ##[1:2]
      o_tbl_pending) else $error("pending not set");
   a_pend_clear: assert property (
      i_ce && o_tbl_load_req && i_tbl_load_done && !i_tbl_entry_wr
      |=> !o_tbl_load_req ##[0:1] !o_tbl_pending)
      else $error("pending not cleared");
   cover property (c_wr && i_wdata[16]);
   cover property (o_tbl_load_req && i_tbl_load_done);
   cover property (i_rd && i_addr == 12'h150);
endmodule : vcr_regs_monitor
bind vcr_regs vcr_regs_monitor i_vcr_regs_monitor (.i_clk(i_clk),
   .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .i_tbl_entry_wr(i_tbl_entry_wr),
   .i_tbl_load_done(i_tbl_load_done), .o_rdata(o_rdata),
   .o_tc_map(o_tc_map), .o_arb_sel(o_arb_sel), .o_vc_en(o_vc_en),
   .o_tbl_load_req(o_tbl_load_req), .o_tbl_pending(o_tbl_pending));

// ===== test/tb.sv
// Self-checking bench for the VC0 resource registers
`timescale 1ns/1ps
module tb;
   logic        i_clk, i_rst, i_wr, i_rd, i_mgmt_wr, i_ent, i_done, i_neg;
   logic        i_ce;
   logic [11:0] i_addr;
   logic [31:0] i_wdata, o_rdata;
   logic [7:0]  i_mgmt_tc_map, o_tc_map;
   logic [2:0]  o_arb_sel;
   logic        o_vc_en, o_req, o_pend;
   int          failures, samples_checked, i;
   vcr_regs i_vcr_regs (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .i_mgmt_wr(i_mgmt_wr), .i_mgmt_tc_map(i_mgmt_tc_map),
      .i_tbl_entry_wr(i_ent), .i_tbl_load_done(i_done),
      .i_neg_pending(i_neg), .o_rdata(o_rdata), .o_tc_map(o_tc_map),
      .o_arb_sel(o_arb_sel), .o_vc_en(o_vc_en), .o_tbl_load_req(o_req),
      .o_tbl_pending(o_pend));
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, e);
   endtask : rd
   task mg(input logic [7:0] v);
      @(posedge i_clk);
      i_mgmt_tc_map <= v;
      i_mgmt_wr <= 1'b1;
      @(posedge i_clk);
      i_mgmt_wr <= 1'b0;
   endtask : mg
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   initial begin
      {i_wr, i_rd, i_mgmt_wr, i_ent, i_done, i_neg} = '0;
      i_ce = 1'b1;
      i_addr = '0;
      i_wdata = '0;
      i_mgmt_tc_map = '0;
      i_rst = 1'b1;
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      #1 chk({o_vc_en, o_arb_sel, o_tc_map, o_req, o_pend}, 32'h23fc);
      mg(8'h5a);
      rd(12'h154, 32'h8000005a);
      mg(8'h33);
      rd(12'h154, 32'h8000005a);
      rd(12'h150, 32'h047f0009);
      wr(12'h150, 32'hffffffff);
      rd(12'h150, 32'h047f0009);
      wr(12'h158, 32'hffffffff);
      rd(12'h158, 32'h0);
      rd(12'h15c, 32'h0);
      for (i = 0; i < 8; i++) begin
         wr(12'h154, {12'hfff, i[2:0], 9'h0ff, i[2:0], 5'h15});
         rd(12'h154, {1'b1, 11'h0, (i == 3) ? 3'h3 : 3'h0, 9'h0, i[2:0],
            5'h15});
         chk(o_arb_sel, (i == 3) ? 3'h3 : 3'h0);
      end
      wr(12'h154, 32'h0);
      rd(12'h154, 32'h0);
      @(posedge i_clk);
      i_ent <= 1'b1;
      @(posedge i_clk);
      i_ent <= 1'b0;
      rd(12'h158, 32'h10000);
      wr(12'h154, 32'h00010000);
      #1 chk(o_req, 1'b1);
      rd(12'h154, 32'h0);
      rd(12'h158, 32'h10000);
      @(posedge i_clk);
      i_done <= 1'b1;
      @(posedge i_clk);
      i_done <= 1'b0;
      rd(12'h158, 32'h0);
      chk(o_req, 1'b0);
      @(posedge i_clk);
      i_ce <= 1'b0;
      wr(12'h154, 32'h800000a5);
      @(posedge i_clk);
      i_ce <= 1'b1;
      rd(12'h154, 32'h0);
      chk(o_tc_map, 8'h0);
      @(posedge i_clk);
      i_neg <= 1'b1;
      repeat (6) @(posedge i_clk);
      rd(12'h158, 32'h20000);
      @(posedge i_clk);
      i_neg <= 1'b0;
      repeat (6) @(posedge i_clk);
      rd(12'h158, 32'h0);
      close_out();
   end
endmodule : tb
